/* File: inc/ascfg_defines.svh */
// Offsets, field positions, reset values and encodings of the step config
`ifndef ASCFG_DEFINES_SVH
`define ASCFG_DEFINES_SVH

// Register word index and APB byte address (index not a multiple of four)
`define ASCFG_IDX_STEP14        8'h9e
`define ASCFG_ADDR_STEP14       12'h278
// Field positions
`define ASCFG_EN_BIT            15
`define ASCFG_GAIN_HI           14
`define ASCFG_GAIN_LO           13
`define ASCFG_NEG_BIT           4
`define ASCFG_POS_HI            3
`define ASCFG_POS_LO            0
// Reset value of the register
`define ASCFG_RESET             16'h000e
// Positive input codes
`define ASCFG_POS_EXT_MAX       4'h7
`define ASCFG_POS_TEMP          4'h8
`define ASCFG_POS_SHORT         4'h9
`define ASCFG_POS_TDAC          4'ha
`define ASCFG_POS_DPWR          4'hf
// Decoded gain factors
`define ASCFG_GAIN_X1           3'h1
`define ASCFG_GAIN_X2           3'h2
`define ASCFG_GAIN_X4           3'h4
// Step number served here
`define ASCFG_STEP_NUM          4'he

`endif

/* File: inc/ascfg_pkg.sv */
// Types shared by the step 14 configuration register
package ascfg_pkg;

  // Source classes for the positive input
  typedef enum logic [2:0] {
    ASCFG_SRC_EXT,
    ASCFG_SRC_TEMP,
    ASCFG_SRC_SHORT,
    ASCFG_SRC_TDAC,
    ASCFG_SRC_MONITOR
  } ascfg_src_t;

  // Mux settings handed to the sequencer
  typedef struct packed {
    logic        step_enable;  // Step 14 active
    logic [2:0]  gain;         // Gain factor 1, 2 or 4
    logic [3:0]  pos_select;   // Positive input code
    logic        neg_ext7;     // Negative input on external input 7
    logic        neg_auto;     // Negative input chosen internally
    ascfg_src_t  pos_source;   // Class of positive source
  } ascfg_sel_t;

  // APB slave outputs
  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } ascfg_apb_rsp_t;

  // Whole module state
  typedef struct packed {
    logic [15:0]    cfg;
    ascfg_apb_rsp_t rsp;
    ascfg_sel_t     sel;
    logic           apply;
  } ascfg_state_t;

endpackage : ascfg_pkg

/* File: hdl/ascfg_step14.sv */
// APB configuration register for sequencer step 14 and its mux decode
//
// What this block does
// - Bit 15 enables step 14
// - Bits 14:13 gain: 1, 2, 4, 4
// - Bit 4 negative: ground or input seven
// - Codes 0-7 route external inputs 0-7
// - Auto-negative codes ignore negative select bit
// - Code 8 selects temperature sensor
// - Code 9 shorts input to ground
// - Code 10 selects test DAC B
// - Codes 11-15 select internal monitor voltages
// - Reset value 000Eh at offset 9Eh
`timescale 1ns/1ps
`default_nettype none
`include "ascfg_defines.svh"

module ascfg_step14 (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  input  wire logic        seq_at_step_i,
  input  wire logic [3:0]  seq_step_i,
  output logic             pready_o,
  output logic [31:0]      prdata_o,
  output logic             pslverr_o,
  output logic [15:0]      cfg_o,
  output logic             step_enable_o,
  output logic [2:0]       gain_o,
  output logic [3:0]       pos_select_o,
  output logic             neg_ext7_o,
  output logic             neg_auto_o,
  output logic [2:0]       pos_source_o,
  output logic             step_apply_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  ascfg_pkg::ascfg_state_t s_q;  // All registered state
  ascfg_pkg::ascfg_state_t s_d;  // Next state

  logic        setup;      // APB setup phase seen
  logic        hit;        // Address decodes to the register
  logic [15:0] wmask;      // Writable bits after byte strobes
  logic [15:0] cfg_new;    // Register after a write
  logic [3:0]  pos;        // Positive code of the new value

  localparam logic [15:0] WR_MASK = 16'he01f;  // Reserved 12:5 read zero

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d     = s_q;
    setup   = psel_i && !penable_i;
    hit     = (paddr_i == `ASCFG_ADDR_STEP14);
    wmask   = WR_MASK & {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
    cfg_new = s_q.cfg;
    // No wait state: answer in the cycle after setup
    s_d.rsp.pready  = 1'b0;
    s_d.rsp.pslverr = 1'b0;
    s_d.rsp.prdata  = 32'h0000_0000;
    if (setup) begin
      s_d.rsp.pready = 1'b1;
      if (!hit) begin
        // Unmapped address: error, reads zero
        s_d.rsp.pslverr = 1'b1;
      end else if (!pwrite_i) begin
        s_d.rsp.prdata = {16'h0000, s_q.cfg};
      end
    end
    // Write lands on the access edge, when pready is high
    if (psel_i && penable_i && s_q.rsp.pready && pwrite_i && hit) begin
      cfg_new = (s_q.cfg & ~wmask) | (pwdata_i[15:0] & wmask);
    end
    s_d.cfg = cfg_new;

    // Decode of the stored settings
    pos = cfg_new[`ASCFG_POS_HI:`ASCFG_POS_LO];
    s_d.sel.step_enable = cfg_new[`ASCFG_EN_BIT];
    // Gain decode, both upper codes are x4
    case (cfg_new[`ASCFG_GAIN_HI:`ASCFG_GAIN_LO])
      2'h0:    s_d.sel.gain = `ASCFG_GAIN_X1;
      2'h1:    s_d.sel.gain = `ASCFG_GAIN_X2;
      default: s_d.sel.gain = `ASCFG_GAIN_X4;
    endcase
    s_d.sel.pos_select = pos;
    // External inputs on codes zero to seven
    if (pos <= `ASCFG_POS_EXT_MAX) begin
      s_d.sel.pos_source = ascfg_pkg::ASCFG_SRC_EXT;
    end else if (pos == `ASCFG_POS_TEMP) begin
      s_d.sel.pos_source = ascfg_pkg::ASCFG_SRC_TEMP;
    end else if (pos == `ASCFG_POS_SHORT) begin
      s_d.sel.pos_source = ascfg_pkg::ASCFG_SRC_SHORT;
    end else if (pos == `ASCFG_POS_TDAC) begin
      s_d.sel.pos_source = ascfg_pkg::ASCFG_SRC_TDAC;
    end else begin
      s_d.sel.pos_source = ascfg_pkg::ASCFG_SRC_MONITOR;
    end
    // Internal codes take the negative input over
    s_d.sel.neg_auto = (pos > `ASCFG_POS_EXT_MAX);
    // Negative select used only for external codes
    s_d.sel.neg_ext7 = cfg_new[`ASCFG_NEG_BIT] && !s_d.sel.neg_auto;
    // Apply only at step 14 while enabled
    s_d.apply = seq_at_step_i && (seq_step_i == `ASCFG_STEP_NUM) &&
                s_q.sel.step_enable;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q.cfg             <= `ASCFG_RESET;
      s_q.rsp             <= '0;
      s_q.sel.step_enable <= 1'b0;
      s_q.sel.gain        <= `ASCFG_GAIN_X1;
      s_q.sel.pos_select  <= 4'he;
      s_q.sel.neg_ext7    <= 1'b0;
      s_q.sel.neg_auto    <= 1'b1;
      s_q.sel.pos_source  <= ascfg_pkg::ASCFG_SRC_MONITOR;
      s_q.apply           <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops
  assign pready_o      = s_q.rsp.pready;
  assign prdata_o      = s_q.rsp.prdata;
  assign pslverr_o     = s_q.rsp.pslverr;
  assign cfg_o         = s_q.cfg;
  assign step_enable_o = s_q.sel.step_enable;
  assign gain_o        = s_q.sel.gain;
  assign pos_select_o  = s_q.sel.pos_select;
  assign neg_ext7_o    = s_q.sel.neg_ext7;
  assign neg_auto_o    = s_q.sel.neg_auto;
  assign pos_source_o  = s_q.sel.pos_source;
  assign step_apply_o  = s_q.apply;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_enable_bit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    step_enable_o == cfg_o[15]) else $error("enable mismatch");
  a_gain_map: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cfg_o[14] |-> gain_o == 3'h4) else $error("gain not x4");
  a_neg_select: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!cfg_o[3]) |-> neg_ext7_o == cfg_o[4]) else $error("neg select wrong");
  a_ext_route: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cfg_o[3:0] < 4'h8) |-> pos_source_o == 3'h0) else $error("ext route");
  a_neg_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cfg_o[3] |-> neg_auto_o && !neg_ext7_o) else $error("neg not auto");
  a_temp_src: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cfg_o[3:0] == 4'h8) |-> pos_source_o == 3'h1) else $error("temp src");
  a_short_src: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cfg_o[3:0] == 4'h9) |-> pos_source_o == 3'h2) else $error("short src");
  a_tdac_src: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cfg_o[3:0] == 4'ha) |-> pos_source_o == 3'h3) else $error("tdac src");
  a_mon_src: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cfg_o[3:0] > 4'ha) |-> pos_source_o == 3'h4) else $error("monitor src");
  a_read_back: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (psel_i && !penable_i && !pwrite_i && hit) |=>
      prdata_o == {16'h0000, $past(cfg_o)}) else $error("read back");
  a_apply_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    step_apply_o |-> $past(step_enable_o)) else $error("apply while off");
  // Ready is a single-cycle answer; a stuck ready would double-commit
  a_ready_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pready_o |=> !pready_o) else $error("pready held");
  // Read data bus is quiet outside the answer cycle
  a_rdata_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !pready_o |-> prdata_o == 32'h0000_0000) else $error("prdata not idle");
  // Reserved bits never hold a one
  a_rsvd_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cfg_o[12:5] == 8'h00) else $error("reserved bits set");
  // Decoded positive code mirrors the stored field
  a_pos_mirror: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pos_select_o == cfg_o[3:0]) else $error("pos select mirror");
  // Apply follows a step 14 visit with the enable set
  a_apply_fires: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (seq_at_step_i && seq_step_i == 4'he && step_enable_o) |=> step_apply_o)
    else $error("apply missed");

endmodule : ascfg_step14

`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the step 14 configuration register
`timescale 1ns/1ps
`default_nettype none
`include "ascfg_defines.svh"

// Compare and count; an unknown matches only the same unknown
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end

module tb;
  logic        clk_i = 1'b0;     // 200 MHz clock
  logic        rst_n_i = 1'b0;   // Async reset, active low
  logic        psel_i = 1'b0;    // APB select
  logic        penable_i = 1'b0; // APB access phase
  logic        pwrite_i = 1'b0;  // APB direction
  logic [11:0] paddr_i = 12'h0;  // APB byte address
  logic [31:0] pwdata_i = 32'h0; // APB write data
  logic [3:0]  pstrb_i = 4'h0;   // APB byte strobes
  logic        seq_at_step_i = 1'b0; // Sequencer at a step
  logic [3:0]  seq_step_i = 4'h0;    // Current step number
  logic        pready_o, pslverr_o, step_enable_o, neg_ext7_o, neg_auto_o;
  logic        step_apply_o;
  logic [31:0] prdata_o, rd;
  logic [15:0] cfg_o;
  logic [2:0]  gain_o, pos_source_o, xsrc, xgain;
  logic [3:0]  pos_select_o;
  logic        er;
  int          err_total = 0;    // Mismatches seen
  int          checked = 0;      // Comparisons made

  ascfg_step14 dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .seq_at_step_i(seq_at_step_i),
    .seq_step_i(seq_step_i), .pready_o(pready_o), .prdata_o(prdata_o),
    .pslverr_o(pslverr_o), .cfg_o(cfg_o), .step_enable_o(step_enable_o),
    .gain_o(gain_o), .pos_select_o(pos_select_o), .neg_ext7_o(neg_ext7_o),
    .neg_auto_o(neg_auto_o), .pos_source_o(pos_source_o),
    .step_apply_o(step_apply_o));

  // Free-running clock
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////
  // One APB transfer; waits for pready, data taken at that edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w;
    paddr_i <= a; pwdata_i <= d; pstrb_i <= s;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // Answer taken at the rising edge where pready is sampled high
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 50) err_total++;
  endtask : apb

  // Verdict and end of run
  task automatic print_verdict;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    `CHK(cfg_o, 16'h000e)
    `CHK({step_enable_o, gain_o, neg_auto_o}, 5'b0_001_1)
    apb(1'b0, `ASCFG_ADDR_STEP14, 32'h0, 4'h0);
    `CHK({er, rd}, {1'b0, 32'h0000_000e})
    // Every positive code, reserved bits and negative bit set on write
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, `ASCFG_ADDR_STEP14,
          {16'hffff, c[0], c[1:0], 8'hff, 1'b1, c[3:0]}, 4'hf);
      @(negedge clk_i);
      xgain = (c[1:0] == 2'b00) ? 3'h1 : (c[1:0] == 2'b01) ? 3'h2 : 3'h4;
      xsrc = (c < 8) ? 3'h0 : (c < 11) ? 3'(c - 7) : 3'h4;
      `CHK(step_enable_o, c[0])
      `CHK(gain_o, xgain)
      `CHK(neg_ext7_o, (c < 8))
      `CHK(neg_auto_o, (c >= 8))
      `CHK(pos_select_o, c[3:0])
      `CHK(pos_source_o, xsrc)
      apb(1'b0, `ASCFG_ADDR_STEP14, 32'h0, 4'h0);
      `CHK(rd, {16'h0, c[0], c[1:0], 8'h0, 1'b1, c[3:0]})
      // Sequencer reaches step 14: applied only when enabled
      @(posedge clk_i);
      seq_at_step_i <= 1'b1; seq_step_i <= 4'he;
      @(posedge clk_i);
      seq_at_step_i <= 1'b1; seq_step_i <= 4'hd;
      @(negedge clk_i);
      `CHK(step_apply_o, c[0])
      @(posedge clk_i);
      seq_at_step_i <= 1'b0;
      @(negedge clk_i);
      `CHK(step_apply_o, 1'b0)
    end
    // Byte strobes: upper byte only, then lower byte only
    apb(1'b1, `ASCFG_ADDR_STEP14, 32'h0000_0000, 4'h2);
    apb(1'b0, `ASCFG_ADDR_STEP14, 32'h0, 4'h0);
    `CHK(rd, 32'h0000_001f)
    apb(1'b1, `ASCFG_ADDR_STEP14, 32'h0000_0007, 4'h1);
    apb(1'b0, `ASCFG_ADDR_STEP14, 32'h0, 4'h0);
    `CHK(rd, 32'h0000_0007)
    @(negedge clk_i);
    `CHK({neg_ext7_o, neg_auto_o}, 2'b00)
    // Unmapped address: error, ignored write, zero read
    apb(1'b1, 12'h27c, 32'h0000_e01a, 4'hf);
    `CHK(er, 1'b1)
    apb(1'b0, 12'h27c, 32'h0, 4'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    `CHK(cfg_o, 16'h0007)
    // Second reset in mid-run restores the default
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    `CHK(cfg_o, 16'h000e)
    `CHK(pos_source_o, 3'h4)
    print_verdict();
  end
endmodule : tb

`default_nettype wire
